// file: inc/lcd_cmd_pkg.sv
package lcd_cmd_pkg;

    localparam logic [5:0] OFF_CMD = 6'h00;
    localparam logic [5:0] OFF_STATUS = 6'h04;
    localparam logic [5:0] OFF_SETTINGS = 6'h08;
    localparam logic [5:0] OFF_ICONS = 6'h0c;
    localparam logic [5:0] OFF_RAMRD = 6'h10;

    localparam int CMD_SEL_BIT = 8;

    localparam logic [3:0] NIB_TEST = 4'h0;
    localparam logic [3:0] NIB_HOME_SCROLL = 4'h1;
    localparam logic [3:0] NIB_BLINK_TALL = 4'h2;
    localparam logic [3:0] NIB_DISPLAY = 4'h3;
    localparam logic [3:0] NIB_POWER_SAVE = 4'h4;
    localparam logic [3:0] NIB_POWER_CTL = 4'h5;
    localparam logic [3:0] NIB_SYSTEM = 4'h6;

    localparam logic [6:0] HOME_ADDR = 7'h30;
    localparam logic [6:0] SYMBOL_END = 7'h10;
    localparam logic [6:0] CHAR_BASE = 7'h30;
    localparam logic [6:0] CHAR_LAST = 7'h6f;
    localparam logic [6:0] ICON_ON_LO = 7'h70;
    localparam logic [6:0] ICON_ON_HI = 7'h71;
    localparam logic [6:0] ICON_BLINK_LO = 7'h72;
    localparam logic [6:0] ICON_BLINK_HI = 7'h73;
    localparam logic [6:0] VOLUME_ADDR = 7'h74;

    localparam int CLK_HZ = 25_000_000;
    localparam int CLK_PERIOD_NS = 40;
    localparam int START_DELAY_NS = 1000;
    localparam int STARTUP_CYC = (START_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CMD_EXEC_NS = 200;
    localparam int CMD_EXEC_CYC = (CMD_EXEC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BLINK_PERIOD_MS = 750;
    localparam int BLINK_HALF_CYC = (CLK_HZ / 1000) * BLINK_PERIOD_MS / 2;
    localparam int BLINK_CNT_W = 24;

    typedef struct packed {
        logic [1:0] scroll_amount;
        logic [3:0] line_reverse_blink;
        logic [3:0] tall_line;
        logic cursor_show;
        logic cursor_blink;
        logic display_on;
        logic ext_bank_select;
        logic osc_run;
        logic low_power_save;
        logic strong_drive;
        logic regulator_on;
        logic follower_on;
        logic booster_on;
        logic internal_divider_sel;
        logic bias_sel;
        logic [1:0] divider_ratio;
        logic user_glyph_enable;
        logic com_right_shift;
        logic seg_reverse;
        logic [1:0] rom_bank;
        logic [4:0] volume;
    } ctrl_t;

    localparam ctrl_t CTRL_RST = '{internal_divider_sel: 1'b1, default: '0};

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ACK = 2'b10
    } bus_state_t;

endpackage

// file: core/lcd_cmd_ctrl.sv
`timescale 1ns/1ps
module lcd_cmd_ctrl
    import lcd_cmd_pkg::*;
#(
    parameter int BLINK_HALF = BLINK_HALF_CYC
) (
    input wire logic CLOCK_I,
    input wire logic RST_N_I,
    input wire logic [5:0] AVS_ADDRESS_I,
    input wire logic AVS_READ_I,
    input wire logic AVS_WRITE_I,
    input wire logic [31:0] AVS_WRITEDATA_I,
    input wire logic [3:0] AVS_BYTEENABLE_I,
    output logic [31:0] AVS_READDATA_O,
    output logic AVS_WAITREQUEST_O,
    output ctrl_t CTRL_O,
    output logic LCD_SUPPLY_LEVEL_O,
    output logic SLEEP_O,
    output logic BLINK_PHASE_O,
    output logic [3:0] LINE_REVERSE_O,
    output logic [9:0] ICON_SEG_O,
    output logic [6:0] CURSOR_ADDR_O,
    output logic TEST_MODE_O
);

    bus_state_t state_r;
    logic waitreq_r;
    logic [31:0] readdata_r;
    logic [7:0] busy_r;
    ctrl_t ctrl_r;
    logic test_mode_r;
    logic [6:0] addr_r;
    logic glyph_area_r;
    logic last_base_r;
    logic [6:0] cursor_r;
    logic [9:0] icon_on_r;
    logic [9:0] icon_blink_r;
    logic [BLINK_CNT_W-1:0] blink_cnt_r;
    logic blink_phase_r;
    logic [7:0] char_ram [0:63];
    logic [7:0] glyph_ram [0:63];
    logic [7:0] symbol_ram [0:15];

    logic acc;
    logic wr_cmd;
    logic is_data;
    logic [7:0] byte_in;
    logic [3:0] nib;
    logic ext;
    logic tgt_char;
    logic tgt_symbol;
    logic [6:0] char_off;
    logic [6:0] addr_nxt;
    logic [7:0] ram_byte;
    logic [31:0] rd_nxt;
    logic cmd_addr;

    assign acc = (state_r == BUS_ACK);
    assign cmd_addr = (AVS_ADDRESS_I == OFF_CMD);
    // Master samples waitrequest low at the ACK edge, so the write lands there
    assign wr_cmd = acc && AVS_WRITE_I && cmd_addr && AVS_BYTEENABLE_I[0];
    assign is_data = AVS_WRITEDATA_I[CMD_SEL_BIT] && AVS_BYTEENABLE_I[1];
    assign byte_in = AVS_WRITEDATA_I[7:0];
    assign nib = byte_in[7:4];
    assign ext = ctrl_r.ext_bank_select;
    assign char_off = addr_r - CHAR_BASE;
    assign tgt_char = !glyph_area_r && (addr_r >= CHAR_BASE) && (addr_r <= CHAR_LAST);
    assign tgt_symbol = !glyph_area_r && (addr_r < SYMBOL_END);
    // Glyph area wraps inside its 64 bytes
    assign addr_nxt = glyph_area_r ? {1'b0, addr_r[5:0] + 6'h01} : addr_r + 7'h01;

    always_comb begin
        ram_byte = 8'h00;
        if (glyph_area_r) begin
            ram_byte = glyph_ram[addr_r[5:0]];
        end else if (tgt_char) begin
            ram_byte = char_ram[char_off[5:0]];
        end else if (tgt_symbol) begin
            ram_byte = symbol_ram[addr_r[3:0]];
        end
    end

    always_comb begin
        rd_nxt = 32'h0000_0000;
        if (AVS_ADDRESS_I == OFF_STATUS) begin
            rd_nxt = {18'h00000, ctrl_r.volume[4:3], busy_r != 8'h00, test_mode_r,
                      ctrl_r.low_power_save & ~ctrl_r.osc_run, last_base_r, glyph_area_r, addr_r};
        end else if (AVS_ADDRESS_I == OFF_SETTINGS) begin
            rd_nxt = ctrl_r[33:2];
        end else if (AVS_ADDRESS_I == OFF_ICONS) begin
            rd_nxt = {12'h000, icon_blink_r, icon_on_r};
        end else if (AVS_ADDRESS_I == OFF_RAMRD) begin
            rd_nxt = {24'h000000, ram_byte};
        end
    end

    // Bus handshake; command writes stall while the interpreter is busy
    always_ff @(posedge CLOCK_I) begin
        if (!RST_N_I) begin
            state_r <= BUS_IDLE;
            waitreq_r <= 1'b1;
            readdata_r <= 32'h0000_0000;
        end else begin
            case (state_r)
                BUS_IDLE: begin
                    if ((AVS_READ_I || AVS_WRITE_I) && !(AVS_WRITE_I && cmd_addr && busy_r != 8'h00)) begin
                        state_r <= BUS_ACK;
                        waitreq_r <= 1'b0;
                        readdata_r <= AVS_READ_I ? rd_nxt : 32'h0000_0000;
                    end
                end
                BUS_ACK: begin
                    state_r <= BUS_IDLE;
                    waitreq_r <= 1'b1;
                end
                default: begin
                    state_r <= BUS_IDLE;
                    waitreq_r <= 1'b1;
                end
            endcase
        end
    end

    // Startup hold after reset and per-command execution time
    always_ff @(posedge CLOCK_I) begin
        if (!RST_N_I) begin
            busy_r <= 8'(STARTUP_CYC);
        end else if (wr_cmd) begin
            busy_r <= 8'(CMD_EXEC_CYC);
        end else if (busy_r != 8'h00) begin
            busy_r <= busy_r - 8'h01;
        end
    end

    // Control settings; only defined bits of each command are looked at
    always_ff @(posedge CLOCK_I) begin
        if (!RST_N_I) begin
            ctrl_r <= CTRL_RST;
            test_mode_r <= 1'b0;
        end else if (wr_cmd) begin
            if (is_data) begin
                if (!glyph_area_r && addr_r == VOLUME_ADDR) begin
                    ctrl_r.volume <= byte_in[4:0];
                end
            end else begin
                case (nib)
                    NIB_TEST: begin
                        test_mode_r <= (byte_in[3:0] != 4'h0);
                    end
                    NIB_HOME_SCROLL: begin
                        if (ext) begin
                            ctrl_r.scroll_amount <= byte_in[1:0];
                        end else begin
                            ctrl_r.scroll_amount <= 2'b00;
                        end
                    end
                    NIB_BLINK_TALL: begin
                        if (ext) begin
                            ctrl_r.tall_line <= byte_in[3:0];
                        end else begin
                            ctrl_r.line_reverse_blink <= byte_in[3:0];
                        end
                    end
                    NIB_DISPLAY: begin
                        ctrl_r.cursor_show <= byte_in[3];
                        ctrl_r.cursor_blink <= byte_in[2];
                        ctrl_r.ext_bank_select <= byte_in[1];
                        ctrl_r.display_on <= byte_in[0];
                    end
                    NIB_POWER_SAVE: begin
                        ctrl_r.osc_run <= byte_in[1];
                        ctrl_r.low_power_save <= byte_in[0];
                    end
                    NIB_POWER_CTL: begin
                        if (ext) begin
                            ctrl_r.internal_divider_sel <= byte_in[3];
                            ctrl_r.bias_sel <= byte_in[2];
                            ctrl_r.divider_ratio <= byte_in[1:0];
                        end else begin
                            ctrl_r.strong_drive <= byte_in[3];
                            ctrl_r.regulator_on <= byte_in[2];
                            ctrl_r.follower_on <= byte_in[1];
                            ctrl_r.booster_on <= byte_in[0];
                        end
                    end
                    NIB_SYSTEM: begin
                        if (ext) begin
                            ctrl_r.seg_reverse <= byte_in[1];
                        end else begin
                            ctrl_r.rom_bank <= byte_in[3:2];
                            ctrl_r.com_right_shift <= byte_in[1];
                            ctrl_r.user_glyph_enable <= byte_in[0];
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // Address counter, target area and cursor position
    always_ff @(posedge CLOCK_I) begin
        if (!RST_N_I) begin
            addr_r <= HOME_ADDR;
            glyph_area_r <= 1'b0;
            last_base_r <= 1'b1;
            cursor_r <= HOME_ADDR;
        end else if (wr_cmd) begin
            if (is_data) begin
                addr_r <= addr_nxt;
                cursor_r <= addr_nxt;
                last_base_r <= !glyph_area_r;
            end else if (byte_in[7]) begin
                // Glyph area holds only 64 bytes, so its address is six bits
                addr_r <= ext ? {1'b0, byte_in[5:0]} : byte_in[6:0];
                glyph_area_r <= ext;
                cursor_r <= ext ? {1'b0, byte_in[5:0]} : byte_in[6:0];
            end else if (nib == NIB_HOME_SCROLL && !ext) begin
                addr_r <= HOME_ADDR;
                glyph_area_r <= 1'b0;
                if (last_base_r) begin
                    cursor_r <= HOME_ADDR;
                end
            end
        end
    end

    // Static icon data; output keeps last state while oscillator is stopped
    always_ff @(posedge CLOCK_I) begin
        if (!RST_N_I) begin
            icon_on_r <= 10'h000;
            icon_blink_r <= 10'h000;
        end else if (wr_cmd && is_data && !glyph_area_r) begin
            if (addr_r == ICON_ON_LO) begin
                icon_on_r[7:0] <= byte_in;
            end else if (addr_r == ICON_ON_HI) begin
                icon_on_r[9:8] <= byte_in[1:0];
            end else if (addr_r == ICON_BLINK_LO) begin
                icon_blink_r[7:0] <= byte_in;
            end else if (addr_r == ICON_BLINK_HI) begin
                icon_blink_r[9:8] <= byte_in[1:0];
            end
        end
    end

    // RAM contents have no reset so they survive reset-free sleep cycles
    always_ff @(posedge CLOCK_I) begin
        if (wr_cmd && is_data) begin
            if (glyph_area_r) begin
                glyph_ram[addr_r[5:0]] <= byte_in;
            end else if (tgt_char) begin
                char_ram[char_off[5:0]] <= byte_in;
            end else if (tgt_symbol) begin
                symbol_ram[addr_r[3:0]] <= byte_in;
            end
        end
    end

    // Shared blink timebase for cursor, lines and icons; stops with oscillator
    always_ff @(posedge CLOCK_I) begin
        if (!RST_N_I) begin
            blink_cnt_r <= '0;
            blink_phase_r <= 1'b0;
        end else if (ctrl_r.osc_run) begin
            if (blink_cnt_r == BLINK_CNT_W'(BLINK_HALF - 1)) begin
                blink_cnt_r <= '0;
                blink_phase_r <= ~blink_phase_r;
            end else begin
                blink_cnt_r <= blink_cnt_r + 1'b1;
            end
        end
    end

    // Registered outputs
    always_ff @(posedge CLOCK_I) begin
        if (!RST_N_I) begin
            CTRL_O <= CTRL_RST;
            LCD_SUPPLY_LEVEL_O <= 1'b0;
            SLEEP_O <= 1'b0;
            BLINK_PHASE_O <= 1'b0;
            LINE_REVERSE_O <= 4'h0;
            ICON_SEG_O <= 10'h000;
            CURSOR_ADDR_O <= HOME_ADDR;
            TEST_MODE_O <= 1'b0;
        end else begin
            CTRL_O <= ctrl_r;
            LCD_SUPPLY_LEVEL_O <= ctrl_r.low_power_save;
            SLEEP_O <= ctrl_r.low_power_save & ~ctrl_r.osc_run;
            BLINK_PHASE_O <= blink_phase_r;
            LINE_REVERSE_O <= ctrl_r.low_power_save ? 4'h0 : ctrl_r.line_reverse_blink & {4{blink_phase_r}};
            if (ctrl_r.osc_run) begin
                ICON_SEG_O <= icon_on_r & ~(icon_blink_r & {10{blink_phase_r}});
            end
            CURSOR_ADDR_O <= cursor_r;
            TEST_MODE_O <= test_mode_r;
        end
    end

    assign AVS_READDATA_O = readdata_r;
    assign AVS_WAITREQUEST_O = waitreq_r;

endmodule

// file: tb/lcd_cmd_ctrl_props.sv
`timescale 1ns/1ps
module lcd_cmd_ctrl_props
    import lcd_cmd_pkg::*;
#(
    parameter int BLINK_HALF = 8
) (
    input wire logic CLOCK_I,
    input wire logic RST_N_I,
    input wire logic [5:0] AVS_ADDRESS_I,
    input wire logic AVS_READ_I,
    input wire logic AVS_WRITE_I,
    input wire logic [31:0] AVS_WRITEDATA_I,
    input wire logic [3:0] AVS_BYTEENABLE_I,
    input wire logic AVS_WAITREQUEST_O,
    input wire ctrl_t CTRL_O,
    input wire logic LCD_SUPPLY_LEVEL_O,
    input wire logic SLEEP_O,
    input wire logic BLINK_PHASE_O,
    input wire logic [3:0] LINE_REVERSE_O,
    input wire logic [9:0] ICON_SEG_O,
    input wire logic [6:0] CURSOR_ADDR_O,
    input wire logic TEST_MODE_O
);
    logic take;
    logic [5:0] since_rst_r;
    logic [3:0] since_cmd_r;
    int ph_cnt_r;
    logic ph_seen_r;
    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (!RST_N_I);
    assign take = AVS_WRITE_I && !AVS_WAITREQUEST_O && AVS_ADDRESS_I == OFF_CMD && AVS_BYTEENABLE_I[0];
    // Saturating, so long runs never wrap
    always_ff @(posedge CLOCK_I) begin
        if (!RST_N_I) since_rst_r <= '0;
        else if (since_rst_r != 6'h3f) since_rst_r <= since_rst_r + 6'h01;
    end
    always_ff @(posedge CLOCK_I) begin
        if (!RST_N_I || take) since_cmd_r <= '0;
        else if (since_cmd_r != 4'hf) since_cmd_r <= since_cmd_r + 4'h1;
    end
    // Only timed after the first phase change seen since the oscillator ran with low power save off
    always_ff @(posedge CLOCK_I) begin
        if (!RST_N_I || !CTRL_O.osc_run || CTRL_O.low_power_save) begin
            ph_cnt_r <= 0;
            ph_seen_r <= 1'b0;
        end else if ($changed(BLINK_PHASE_O)) begin
            ph_cnt_r <= 1;
            ph_seen_r <= 1'b1;
        end else ph_cnt_r <= ph_cnt_r + 1;
    end
    sequence quiet_s;
        ($stable(CTRL_O) && $stable(BLINK_PHASE_O)) [*3];
    endsequence
    reset_vals_a: assert property (disable iff (1'b0)
        !RST_N_I [*3] |-> CTRL_O == CTRL_RST && AVS_WAITREQUEST_O && !TEST_MODE_O && !SLEEP_O)
        else $error("reset state wrong");
    wait_pulse_a: assert property (!AVS_WAITREQUEST_O |=> AVS_WAITREQUEST_O)
        else $error("waitrequest low too long");
    read_answer_a: assert property ($rose(AVS_READ_I) |=> !AVS_WAITREQUEST_O)
        else $error("read not answered");
    start_stall_a: assert property (take |-> since_rst_r >= 6'd25)
        else $error("command taken too soon after reset");
    cmd_space_a: assert property (take |-> since_cmd_r >= 4'd5)
        else $error("commands too close");
    sleep_out_a: assert property (quiet_s |-> SLEEP_O == (CTRL_O.low_power_save && !CTRL_O.osc_run))
        else $error("sleep flag wrong");
    supply_out_a: assert property (quiet_s |-> LCD_SUPPLY_LEVEL_O == CTRL_O.low_power_save)
        else $error("supply level forcing wrong");
    line_rev_a: assert property (quiet_s |-> LINE_REVERSE_O ==
        (CTRL_O.low_power_save ? 4'h0 : CTRL_O.line_reverse_blink & {4{BLINK_PHASE_O}}))
        else $error("line reverse output wrong");
    icon_freeze_a: assert property (quiet_s ##0 !CTRL_O.osc_run |-> $stable(ICON_SEG_O))
        else $error("icons moved with oscillator off");
    blink_rate_a: assert property (ph_seen_r && $changed(BLINK_PHASE_O) |->
        ph_cnt_r >= BLINK_HALF && ph_cnt_r <= BLINK_HALF + 1) else $error("blink half period wrong");
    blink_live_a: assert property (ph_seen_r |-> ph_cnt_r <= BLINK_HALF + 2)
        else $error("blink timebase stuck");
    test_clear_a: assert property (take && AVS_WRITEDATA_I[8:0] == 9'h000 |-> ##[1:8] !TEST_MODE_O)
        else $error("nop left test flag set");
    test_set_a: assert property (take && AVS_WRITEDATA_I[8:4] == 5'h00 && AVS_WRITEDATA_I[3:0] != 4'h0
        |-> ##[1:8] TEST_MODE_O) else $error("test code ignored");
endmodule

bind lcd_cmd_ctrl lcd_cmd_ctrl_props #(.BLINK_HALF(BLINK_HALF)) props (.CLOCK_I(CLOCK_I), .RST_N_I(RST_N_I),
    .AVS_ADDRESS_I(AVS_ADDRESS_I), .AVS_READ_I(AVS_READ_I), .AVS_WRITE_I(AVS_WRITE_I),
    .AVS_WRITEDATA_I(AVS_WRITEDATA_I), .AVS_BYTEENABLE_I(AVS_BYTEENABLE_I), .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O),
    .CTRL_O(CTRL_O), .LCD_SUPPLY_LEVEL_O(LCD_SUPPLY_LEVEL_O), .SLEEP_O(SLEEP_O), .BLINK_PHASE_O(BLINK_PHASE_O),
    .LINE_REVERSE_O(LINE_REVERSE_O), .ICON_SEG_O(ICON_SEG_O), .CURSOR_ADDR_O(CURSOR_ADDR_O),
    .TEST_MODE_O(TEST_MODE_O));

// file: tb/lcd_host_model.sv
`timescale 1ns/1ps
module lcd_host_model (
    input wire logic clk_i,
    input wire logic waitrequest_i,
    input wire logic [31:0] readdata_i,
    output logic [5:0] address_o,
    output logic read_o,
    output logic write_o,
    output logic [31:0] writedata_o,
    output logic [3:0] byteenable_o
);
    initial begin
        address_o = '0;
        read_o = 1'b0;
        write_o = 1'b0;
        writedata_o = '0;
        byteenable_o = '0;
    end
    // Next request only after the answer, so the device paces instructions
    task automatic xfer(input logic wr, input logic [5:0] a, input logic [31:0] d, input logic [3:0] be,
            output logic [31:0] q, output logic to);
        int n;
        @(posedge clk_i);
        address_o <= a;
        write_o <= wr;
        read_o <= !wr;
        writedata_o <= d;
        byteenable_o <= be;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (waitrequest_i !== 1'b0 && n < 100);
        q = readdata_i;
        to = (n >= 100);
        write_o <= 1'b0;
        read_o <= 1'b0;
        // Released data lines must not look valid
        writedata_o <= ~d;
    endtask
endmodule

// file: tb/test_lcd_display_control_cmds.sv
`timescale 1ns/1ps
module test_lcd_display_control_cmds;
    import lcd_cmd_pkg::*;
    logic CLOCK_I, RST_N_I, AVS_READ_I, AVS_WRITE_I, AVS_WAITREQUEST_O, LCD_SUPPLY_LEVEL_O, SLEEP_O;
    logic BLINK_PHASE_O, TEST_MODE_O;
    logic [5:0] AVS_ADDRESS_I;
    logic [31:0] AVS_WRITEDATA_I, AVS_READDATA_O, q, r;
    logic [3:0] AVS_BYTEENABLE_I, LINE_REVERSE_O;
    logic [3:0] tbl [5];
    logic [9:0] ICON_SEG_O, icon, iblk;
    logic [6:0] CURSOR_ADDR_O, ac, cur;
    ctrl_t CTRL_O, e;
    logic glyph, hi, lo;
    int errors, comparisons, seed, i;

    lcd_cmd_ctrl #(.BLINK_HALF(8)) DUT (.CLOCK_I(CLOCK_I), .RST_N_I(RST_N_I), .AVS_ADDRESS_I(AVS_ADDRESS_I),
        .AVS_READ_I(AVS_READ_I), .AVS_WRITE_I(AVS_WRITE_I), .AVS_WRITEDATA_I(AVS_WRITEDATA_I),
        .AVS_BYTEENABLE_I(AVS_BYTEENABLE_I), .AVS_READDATA_O(AVS_READDATA_O), .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O),
        .CTRL_O(CTRL_O), .LCD_SUPPLY_LEVEL_O(LCD_SUPPLY_LEVEL_O), .SLEEP_O(SLEEP_O), .BLINK_PHASE_O(BLINK_PHASE_O),
        .LINE_REVERSE_O(LINE_REVERSE_O), .ICON_SEG_O(ICON_SEG_O), .CURSOR_ADDR_O(CURSOR_ADDR_O),
        .TEST_MODE_O(TEST_MODE_O));
    lcd_host_model host (.clk_i(CLOCK_I), .waitrequest_i(AVS_WAITREQUEST_O), .readdata_i(AVS_READDATA_O),
        .address_o(AVS_ADDRESS_I), .read_o(AVS_READ_I), .write_o(AVS_WRITE_I), .writedata_o(AVS_WRITEDATA_I),
        .byteenable_o(AVS_BYTEENABLE_I));

    initial begin
        CLOCK_I = 1'b0;
        forever #20 CLOCK_I = ~CLOCK_I;
    end

    task automatic summarize();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_ctrl();
        comparisons++;
        if (CTRL_O !== e) begin
            errors++;
            $display("ERROR CTRL_O expected %h seen %h", e, CTRL_O);
        end
    endtask
    task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d, input logic [3:0] be);
        logic to;
        host.xfer(wr, a, d, be, q, to);
        if (to) begin
            errors++;
            summarize();
        end
    endtask
    task automatic init_model();
        e = CTRL_RST;
        ac = HOME_ADDR;
        glyph = 1'b0;
        icon = '0;
        iblk = '0;
    endtask
    // Execution time plus the registered copy, then settle
    task automatic settle();
        repeat (CMD_EXEC_CYC + 3) @(posedge CLOCK_I);
        @(negedge CLOCK_I);
    endtask
    task automatic cmd(input logic [7:0] b);
        logic x;
        x = e.ext_bank_select;
        bus(1'b1, OFF_CMD, {24'h0, b}, 4'hf);
        if (b[7]) begin
            ac = x ? {1'b0, b[5:0]} : b[6:0];
            glyph = x;
        end else case (b[7:4])
            NIB_HOME_SCROLL: if (x) e.scroll_amount = b[1:0]; else begin
                e.scroll_amount = 2'h0;
                ac = HOME_ADDR;
                glyph = 1'b0;
            end
            NIB_BLINK_TALL: if (x) e.tall_line = b[3:0]; else e.line_reverse_blink = b[3:0];
            NIB_DISPLAY: {e.cursor_show, e.cursor_blink, e.ext_bank_select, e.display_on} = b[3:0];
            NIB_POWER_SAVE: {e.osc_run, e.low_power_save} = b[1:0];
            NIB_POWER_CTL: if (x) {e.internal_divider_sel, e.bias_sel, e.divider_ratio} = b[3:0];
                else {e.strong_drive, e.regulator_on, e.follower_on, e.booster_on} = b[3:0];
            NIB_SYSTEM: if (x) e.seg_reverse = b[1];
                else {e.rom_bank, e.com_right_shift, e.user_glyph_enable} = b[3:0];
            default: ;
        endcase
        settle();
        chk_ctrl();
    endtask
    task automatic dat(input logic [7:0] b);
        bus(1'b1, OFF_CMD, {23'h0, 1'b1, b}, 4'hf);
        if (!glyph && ac == ICON_ON_LO) icon[7:0] = b;
        if (!glyph && ac == ICON_ON_HI) icon[9:8] = b[1:0];
        if (!glyph && ac == ICON_BLINK_LO) iblk[7:0] = b;
        if (!glyph && ac == ICON_BLINK_HI) iblk[9:8] = b[1:0];
        if (!glyph && ac == VOLUME_ADDR) e.volume = b[4:0];
        ac = ac + 7'h01;
        settle();
    endtask

    initial begin
        seed = 32'h3facd32f;
        errors = 0;
        comparisons = 0;
        tbl = '{NIB_HOME_SCROLL, NIB_BLINK_TALL, NIB_DISPLAY, NIB_POWER_CTL, NIB_SYSTEM};
        RST_N_I = 1'b0;
        init_model();
        repeat (8) @(posedge CLOCK_I);
        RST_N_I <= 1'b1;
        @(negedge CLOCK_I);
        chk_ctrl();
        chk("cursor", 32'h30, 32'(CURSOR_ADDR_O));
        bus(1'b0, OFF_SETTINGS, '0, 4'hf);
        chk("settings", 32'(CTRL_RST >> 2), q);
        bus(1'b0, 6'h14, '0, 4'hf);
        chk("unmapped", 32'h0, q);
        $display("test reset done");
        for (i = 0; i < 40; i++) begin
            r = $random(seed);
            cmd({tbl[r[7:4] % 4'd5], r[3:0]});
        end
        $display("test commands done");
        cmd(8'h30);
        cmd(8'hb5);
        for (i = 0; i < 3; i++) dat(8'h41 + 8'(i));
        bus(1'b0, OFF_STATUS, '0, 4'hf);
        chk("addr counter", 32'(ac), 32'(q[6:0]));
        cmd(8'h1f);
        chk("cursor", 32'h30, 32'(CURSOR_ADDR_O));
        cmd(8'h32);
        cmd(8'h85);
        dat(8'h5a);
        cmd(8'h30);
        cur = CURSOR_ADDR_O;
        cmd(8'h10);
        chk("cursor kept", 32'(cur), 32'(CURSOR_ADDR_O));
        bus(1'b0, OFF_STATUS, '0, 4'hf);
        chk("home addr", 32'h30, 32'(q[6:0]));
        r = $random(seed);
        cmd(8'h42);
        cmd(8'hf0);
        dat(r[7:0]);
        dat(r[15:8]);
        dat(r[31:24]);
        dat(8'h00);
        dat(r[23:16]);
        chk_ctrl();
        chk("icons", 32'(icon & ~(iblk & {10{BLINK_PHASE_O}})), 32'(ICON_SEG_O));
        bus(1'b0, OFF_ICONS, '0, 4'hf);
        chk("icon reg", 32'({iblk, icon}), q);
        $display("test data done");
        cmd(8'h2f);
        hi = 1'b0;
        lo = 1'b0;
        for (i = 0; i < 40; i++) begin
            @(negedge CLOCK_I);
            hi = hi | (LINE_REVERSE_O === 4'hf);
            lo = lo | (LINE_REVERSE_O === 4'h0);
        end
        chk("blink", 32'h3, {30'h0, hi, lo});
        // Four icon bytes from 0x70 cleared while the oscillator still runs (bank select is clear), then power down in order
        cmd(8'hf0);
        for (i = 0; i < 4; i++) dat(8'h00);
        cmd(8'h50);
        cmd(8'h40);
        cmd(8'h41);
        chk("sleep", 32'h7, {29'h0, SLEEP_O, LCD_SUPPLY_LEVEL_O, LINE_REVERSE_O === 4'h0});
        cmd(8'h42);
        chk("awake", 32'h0, 32'(SLEEP_O));
        cmd(8'hb5);
        bus(1'b0, OFF_RAMRD, '0, 4'hf);
        chk("ram kept", 32'h41, 32'(q[7:0]));
        $display("test sleep done");
        cmd(8'h07);
        chk("test flag", 32'h1, 32'(TEST_MODE_O));
        cmd(8'h00);
        chk("test flag", 32'h0, 32'(TEST_MODE_O));
        bus(1'b1, OFF_CMD, 32'h37, 4'he);
        settle();
        chk_ctrl();
        $display("test refuse done");
        @(posedge CLOCK_I);
        RST_N_I <= 1'b0;
        init_model();
        repeat (8) @(posedge CLOCK_I);
        @(negedge CLOCK_I);
        chk_ctrl();
        @(posedge CLOCK_I);
        RST_N_I <= 1'b1;
        cmd(8'h3b);
        $display("test second reset done");
        summarize();
    end
endmodule
